// File: asm_path_decode.sv
// Maps a class/instance/attribute path onto one of the assemblies.
// Assumes the path is packed class[23:16], instance[15:8], attr[7:0].
`timescale 1ns/1ns
module asm_path_decode (
	input wire logic [23:0] PATH,
	output valve_head_pkg::asm_t KIND
);
	// Only the data attribute of class 4 names an assembly
	always_comb begin
		KIND = valve_head_pkg::ASM_NONE;
		if (PATH[23:16] == valve_head_pkg::ASM_CLASS &&
		    PATH[7:0] == valve_head_pkg::ASM_ATTR) begin
			unique case (PATH[15:8])
				valve_head_pkg::INST_IN_FB: begin
					KIND = valve_head_pkg::ASM_IN_FB;
				end
				valve_head_pkg::INST_IN_POS: begin
					KIND = valve_head_pkg::ASM_IN_POS;
				end
				valve_head_pkg::INST_OUT: begin
					KIND = valve_head_pkg::ASM_OUT_VALVES;
				end
				default: begin
					KIND = valve_head_pkg::ASM_NONE;
				end
			endcase
		end
	end
endmodule // asm_path_decode

// File: bit_sync.sv
// Two-flop synchroniser for a bus of slow pin levels.
// Assumes each bit changes rarely; bits are not sampled coherently.
`timescale 1ns/1ns
module bit_sync #(
	parameter int WIDTH = 1
) (
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	input wire logic [WIDTH-1:0] PIN_IN,
	output logic [WIDTH-1:0] SYNC_OUT
);
	logic [WIDTH-1:0] meta_q; // First stage, read only by second
	// Both stages clear to zero under reset
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			meta_q <= '0;
			SYNC_OUT <= '0;
		end else begin
			meta_q <= PIN_IN;
			SYNC_OUT <= meta_q;
		end
	end
endmodule // bit_sync

// File: scanner_model.sv
// APB master standing in for the protocol stack and the scanner.
// Assumes one clock and a slave that raises pready in access.
`timescale 1ns/1ns
module scanner_model (
	input wire logic clk,
	input wire logic pready,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata
);
	////////////////////////////////////////
	// Idle bus from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end
	////////////////////////////////////////
	// One transfer: setup, then access held until pready at an edge
	// Reset messages and path setup reach the node here
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		// Released data no longer shows the old value
		pwdata <= ~d;
	endtask
endmodule // scanner_model

// File: test_fieldbus_node_config_process_data.sv
// Self-checking bench for the valve head node block.
// Assumes the package, design files and scanner model come first.
`timescale 1ns/1ns
module test_fieldbus_node_config_process_data;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr, dip, pos;
	logic [31:0] pwdata, prdata, r;
	logic [3:0] fb;
	logic [5:0] node_addr;
	logic [1:0] baud_sel;
	logic baud_bad, cfg_valid;
	logic [2:0] valves;
	logic [32:0] expq[$]; // Notes of {error, read data}
	logic [32:0] resp; // Response seen at completion
	int bad_count, n_checks;
	int cycles = 0;
	////////////////////////////////////////
	// 125 MHz clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	scanner_model u_scan (.clk(clk), .pready(pready), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata));
	valve_head_node dut (.CORE_CLK(clk), .RESET_N(rst_n),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .DIP_SWITCH(dip),
		.FEEDBACK(fb), .POSITION_MM(pos), .NODE_ADDR(node_addr),
		.BAUD_SEL(baud_sel), .BAUD_FORBIDDEN(baud_bad),
		.CFG_VALID(cfg_valid), .VALVE_DRIVE(valves));
	////////////////////////////////////////
	// Verdict and end of run
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Compare one value, count and report
	task automatic check(input string nm, input logic [32:0] seen,
		input logic [32:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin // Several times the whole run
			bad_count++;
			final_report();
		end
	end
	// Each completed transfer retires the oldest note
	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1) begin
			resp = {pslverr, pwrite ? 32'h0 : prdata};
			check("apb", resp, expq.pop_front());
		end
	end
	////////////////////////////////////////
	// Bus tasks: note the expectation, then run the transfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic er);
		expq.push_back({er, 32'h0000_0000});
		u_scan.xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x,
		input logic er);
		expq.push_back({er, x});
		u_scan.xfer(1'b0, a, 32'h0000_0000);
	endtask
	// Configuration pins, sampled mid-cycle
	task automatic pins(input logic [5:0] a, input logic [1:0] b,
		input logic v);
		@(negedge clk);
		check("node", node_addr, a);
		check("baud", baud_sel, b);
		check("forbid", baud_bad, b == 2'h3);
		check("valid", cfg_valid, v);
		@(posedge clk);
	endtask
	// Valve pins two cycles after the cause has landed
	task automatic vchk(input logic [2:0] v);
		repeat (2) @(posedge clk);
		@(negedge clk);
		check("valves", valves, v);
		@(posedge clk);
	endtask
	// Network reset message with new switches, then the capture
	task automatic restart(input logic [7:0] sw);
		dip <= sw;
		wr(valve_head_pkg::REG_CTRL, 32'h0000_0001, 1'b0);
		@(negedge clk);
		check("restart", cfg_valid, 1'b0);
		repeat (6) @(posedge clk);
		pins(sw[5:0], sw[7:6], 1'b1);
		rd(valve_head_pkg::REG_NODE, {15'h0, 1'b1, 3'h0, &sw[7:6],
			2'h0, sw[7:6], 2'h0, sw[5:0]}, 1'b0);
	endtask
	////////////////////////////////////////
	// Main sequence
	initial begin
		rst_n = 1'b0;
		bad_count = 0;
		n_checks = 0;
		r = $urandom(11);
		dip = r[7:0];
		fb = r[11:8];
		pos = r[19:12];
		repeat (3) @(posedge clk);
		pins(6'h00, 2'h0, 1'b0);
		@(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		pins(dip[5:0], dip[7:6], 1'b1);
		// Switch moves in operation are ignored
		r[7:0] = dip;
		dip <= ~dip;
		repeat (10) @(posedge clk);
		pins(r[5:0], r[7:6], 1'b1);
		// Every bit-rate code, address boundaries included
		for (int b = 0; b < 4; b++) begin
			r = $urandom;
			restart({b[1:0], b == 0 ? 6'h00 : b == 3 ? 6'h3F : r[5:0]});
		end
		r = $urandom;
		fb <= r[3:0];
		pos <= r[11:4];
		repeat (4) @(posedge clk);
		// Input assemblies and their selection
		rd(valve_head_pkg::REG_IN, {14'h0, 2'h1, 12'h0, fb}, 1'b0);
		wr(valve_head_pkg::REG_ACTIVE, 32'h0000_1502, 1'b0);
		rd(valve_head_pkg::REG_IN, {14'h0, 2'h2, pos, 4'h0, fb},
			1'b0);
		wr(valve_head_pkg::REG_ACTIVE, 32'h0000_1503, 1'b1);
		wr(valve_head_pkg::REG_ACTIVE, 32'h0000_1601, 1'b1);
		rd(valve_head_pkg::REG_ACTIVE, 32'h0000_1502, 1'b0);
		wr(valve_head_pkg::REG_PATH, 32'h0004_0103, 1'b0);
		rd(valve_head_pkg::REG_IN, {14'h0, 2'h1, 12'h0, fb}, 1'b0);
		rd(valve_head_pkg::REG_ACTIVE, 32'h0000_1501, 1'b0);
		wr(valve_head_pkg::REG_PATH, 32'h0104_1503, 1'b0);
		wr(valve_head_pkg::REG_PATH, 32'h0004_0303, 1'b1);
		wr(valve_head_pkg::REG_PATH, 32'h0104_0103, 1'b1);
		rd(valve_head_pkg::REG_PATH, 32'h0000_0000, 1'b0);
		// Explicit reads by class, instance and attribute
		wr(valve_head_pkg::REG_EXPL_PATH, 32'h0004_0203, 1'b0);
		rd(valve_head_pkg::REG_EXPL_DATA, {1'b1, 13'h0, 2'h2, pos, 4'h0,
			fb}, 1'b0);
		wr(valve_head_pkg::REG_EXPL_PATH, 32'h0004_0103, 1'b0);
		rd(valve_head_pkg::REG_EXPL_DATA, {1'b1, 13'h0, 2'h1, 12'h0,
			fb}, 1'b0);
		wr(valve_head_pkg::REG_EXPL_PATH, 32'h0004_0903, 1'b0);
		rd(valve_head_pkg::REG_EXPL_PATH, 32'h0004_0903, 1'b0);
		rd(valve_head_pkg::REG_EXPL_DATA, 32'h0000_0000, 1'b0);
		// Unmapped place
		rd(8'h40, 32'h0000_0000, 1'b1);
		wr(8'h40, 32'hFFFF_FFFF, 1'b1);
		// Valve drive with link up, then bus loss
		r = $urandom;
		wr(valve_head_pkg::REG_CTRL, 32'h0000_0002, 1'b0);
		wr(valve_head_pkg::REG_OUT, r, 1'b0);
		vchk(r[2:0]);
		rd(valve_head_pkg::REG_OUT, {29'h0, r[2:0]}, 1'b0);
		rd(valve_head_pkg::REG_CTRL, 32'h0000_0002, 1'b0);
		rd(valve_head_pkg::REG_STATUS, {23'h0, 1'b0, fb, 1'b0, r[2:0]},
			1'b0);
		// Explicit read of the output assembly
		wr(valve_head_pkg::REG_EXPL_PATH, 32'h0004_1503, 1'b0);
		rd(valve_head_pkg::REG_EXPL_DATA, {1'b1, 13'h0, 2'h1, 13'h0,
			r[2:0]}, 1'b0);
		wr(valve_head_pkg::REG_SAFETY, 32'h0000_0005, 1'b0);
		rd(valve_head_pkg::REG_SAFETY, 32'h0000_0005, 1'b0);
		wr(valve_head_pkg::REG_CTRL, 32'h0000_0000, 1'b0);
		vchk(3'h5);
		rd(valve_head_pkg::REG_STATUS, {23'h0, 1'b1, fb, 1'b0, 3'h5},
			1'b0);
		wr(valve_head_pkg::REG_SAFETY, 32'h0000_0000, 1'b0);
		vchk(3'h0);
		wr(valve_head_pkg::REG_CTRL, 32'h0000_0002, 1'b0);
		wr(valve_head_pkg::REG_OUT, 32'h0000_0003, 1'b0);
		wr(valve_head_pkg::REG_SAFETY, 32'h0000_0100, 1'b0);
		rd(valve_head_pkg::REG_SAFETY, 32'h0000_0100, 1'b0);
		wr(valve_head_pkg::REG_CTRL, 32'h0000_0000, 1'b0);
		vchk(3'h3);
		// Power cycle in mid-run recaptures the switches
		rst_n <= 1'b0;
		vchk(3'h0);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		pins(dip[5:0], dip[7:6], 1'b1);
		@(posedge clk);
		check("queue", expq.size(), 0);
		final_report();
	end
endmodule // test_fieldbus_node_config_process_data

// File: valve_head_node.sv
// Node configuration and process data block of the valve head.
// Assumes the protocol stack drives APB on CORE_CLK, switch and
// feedback pins are asynchronous, position byte is on CORE_CLK.
`timescale 1ns/1ns
module valve_head_node (
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [7:0] DIP_SWITCH,
	input wire logic [3:0] FEEDBACK,
	input wire logic [7:0] POSITION_MM,
	output logic [5:0] NODE_ADDR,
	output logic [1:0] BAUD_SEL,
	output logic BAUD_FORBIDDEN,
	output logic CFG_VALID,
	output logic [2:0] VALVE_DRIVE
);
	////////////////////////////////////////////////////////////////
	// Types and state
	typedef struct packed {
		valve_head_pkg::cfg_state_t state; // Settle or run
		logic [1:0] settle; // Cycles since restart
		logic [5:0] node_addr; // Captured node address
		logic [1:0] baud; // Captured bit rate code
		valve_head_pkg::asm_t in_asm; // Active input assembly
		logic [2:0] out_cmd; // Output assembly bits 0-2
		logic [2:0] safe_pos; // Valve state on bus loss
		logic safe_retain; // Keep last valves on bus loss
		logic link_up; // Bus communication alive
		logic [2:0] valve; // Valve drive flops
		logic [23:0] expl_path; // Explicit message path
		logic [31:0] rdata; // Read data for access phase
	} state_t;
	state_t s_q; // Registered state
	state_t s_d; // Next state
	////////////////////////////////////////////////////////////////
	// Synchronised pins and path decode
	logic [7:0] dip_s; // Switches after two flops
	logic [3:0] fb_s; // Feedback after two flops
	valve_head_pkg::asm_t path_kind; // Decode of written path
	valve_head_pkg::asm_t expl_kind; // Decode of explicit path
	bit_sync #(.WIDTH(8)) dip_sync (
		.CORE_CLK(CORE_CLK),
		.RESET_N(RESET_N),
		.PIN_IN(DIP_SWITCH),
		.SYNC_OUT(dip_s)
	);
	bit_sync #(.WIDTH(4)) fb_sync (
		.CORE_CLK(CORE_CLK),
		.RESET_N(RESET_N),
		.PIN_IN(FEEDBACK),
		.SYNC_OUT(fb_s)
	);
	asm_path_decode path_dec (
		.PATH(PWDATA[23:0]),
		.KIND(path_kind)
	);
	asm_path_decode expl_dec (
		.PATH(s_q.expl_path),
		.KIND(expl_kind)
	);
	////////////////////////////////////////////////////////////////
	// Bus decode
	logic setup_rd; // Read setup cycle
	logic wr_en; // Write takes effect
	logic mapped; // Address is a register
	logic bad_wr; // Write refused with error
	logic [7:0] in_b0; // Feedback byte, bits 4-7 zero
	logic [7:0] in_b1; // Position byte or zero
	logic [1:0] in_len; // Active input length in bytes
	logic [31:0] expl_data; // Explicit read data
	logic path_in_ok; // Path names the output assembly if consumed, else an input one
	logic act_in_ok; // Active input instance is legal
	valve_head_pkg::asm_t act_kind; // Kind from instance write
	assign setup_rd = PSEL && !PENABLE && !PWRITE;
	assign wr_en = PSEL && PENABLE && PWRITE && !bad_wr;
	assign PREADY = 1'b1;
	assign PRDATA = s_q.rdata;
	assign PSLVERR = PSEL && PENABLE && (!mapped || bad_wr);
	// Known offsets
	always_comb begin
		unique case (PADDR)
			valve_head_pkg::REG_NODE, valve_head_pkg::REG_CTRL,
			valve_head_pkg::REG_ACTIVE, valve_head_pkg::REG_PATH,
			valve_head_pkg::REG_OUT, valve_head_pkg::REG_IN,
			valve_head_pkg::REG_EXPL_PATH, valve_head_pkg::REG_EXPL_DATA,
			valve_head_pkg::REG_SAFETY, valve_head_pkg::REG_STATUS: begin
				mapped = 1'b1;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end
	// Input instance written into the active assembly register
	always_comb begin
		unique case (PWDATA[7:0])
			valve_head_pkg::INST_IN_FB: begin
				act_kind = valve_head_pkg::ASM_IN_FB;
			end
			valve_head_pkg::INST_IN_POS: begin
				act_kind = valve_head_pkg::ASM_IN_POS;
			end
			default: begin
				act_kind = valve_head_pkg::ASM_NONE;
			end
		endcase
	end
	assign act_in_ok = act_kind != valve_head_pkg::ASM_NONE &&
		PWDATA[15:8] == valve_head_pkg::INST_OUT;
	assign path_in_ok = PWDATA[valve_head_pkg::PATH_CONSUMED] ?
		path_kind == valve_head_pkg::ASM_OUT_VALVES :
		(path_kind == valve_head_pkg::ASM_IN_FB ||
		 path_kind == valve_head_pkg::ASM_IN_POS);
	// Illegal selections are refused and leave state unchanged
	assign bad_wr = PWRITE &&
		((PADDR == valve_head_pkg::REG_ACTIVE && !act_in_ok) ||
		 (PADDR == valve_head_pkg::REG_PATH && !path_in_ok));
	////////////////////////////////////////////////////////////////
	// Input assembly contents
	assign in_b0 = {4'h0, fb_s};
	assign in_b1 = (s_q.in_asm == valve_head_pkg::ASM_IN_POS) ?
		POSITION_MM : 8'h00;
	assign in_len = (s_q.in_asm == valve_head_pkg::ASM_IN_POS) ?
		2'h2 : 2'h1;
	// Explicit message read of the addressed assembly attribute
	always_comb begin
		expl_data = 32'h0000_0000;
		unique case (expl_kind)
			valve_head_pkg::ASM_IN_FB: begin
				expl_data = {14'h0000, 2'h1, 8'h00, in_b0};
				expl_data[valve_head_pkg::EXPL_OK] = 1'b1;
			end
			valve_head_pkg::ASM_IN_POS: begin
				expl_data = {14'h0000, 2'h2, POSITION_MM, in_b0};
				expl_data[valve_head_pkg::EXPL_OK] = 1'b1;
			end
			valve_head_pkg::ASM_OUT_VALVES: begin
				expl_data = {14'h0000, 2'h1, 13'h0000, s_q.out_cmd};
				expl_data[valve_head_pkg::EXPL_OK] = 1'b1;
			end
			valve_head_pkg::ASM_NONE: begin
				expl_data = 32'h0000_0000;
			end
		endcase
	end
	////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		s_d = s_q;
		// Restart capture: wait for synchronisers, then latch
		unique case (s_q.state)
			valve_head_pkg::CFG_SETTLE: begin
				s_d.settle = s_q.settle + 2'h1;
				if (s_q.settle == valve_head_pkg::SETTLE_LAST) begin
					s_d.node_addr = dip_s[5:0];
					s_d.baud = {dip_s[7], dip_s[6]};
					s_d.state = valve_head_pkg::CFG_RUN;
				end
			end
			valve_head_pkg::CFG_RUN: begin
				s_d.settle = 2'h0; // Switches ignored here
			end
		endcase
		// Register writes
		if (wr_en) begin
			unique case (PADDR)
				valve_head_pkg::REG_CTRL: begin
					s_d.link_up = PWDATA[valve_head_pkg::CTRL_LINK_UP];
					if (PWDATA[valve_head_pkg::CTRL_RESTART]) begin
						// Reset message: recapture, defaults
						s_d.state = valve_head_pkg::CFG_SETTLE;
						s_d.settle = 2'h0;
						s_d.link_up = 1'b0;
						s_d.out_cmd = 3'h0;
						s_d.in_asm = valve_head_pkg::ASM_IN_FB;
					end
				end
				valve_head_pkg::REG_ACTIVE: begin
					s_d.in_asm = act_kind;
				end
				valve_head_pkg::REG_PATH: begin
					if (!PWDATA[valve_head_pkg::PATH_CONSUMED]) begin
						s_d.in_asm = path_kind;
					end
				end
				valve_head_pkg::REG_OUT: begin
					s_d.out_cmd = PWDATA[2:0];
				end
				valve_head_pkg::REG_EXPL_PATH: begin
					s_d.expl_path = PWDATA[23:0];
				end
				valve_head_pkg::REG_SAFETY: begin
					s_d.safe_pos = PWDATA[2:0];
					s_d.safe_retain = PWDATA[valve_head_pkg::SAFE_RETAIN];
				end
				default: begin
					s_d.rdata = s_q.rdata; // Read-only or unmapped
				end
			endcase
		end
		// Valve drive: command while link up, safety state on loss unless retain holds them
		if (s_q.link_up) begin
			s_d.valve = s_q.out_cmd;
		end else if (!s_q.safe_retain) begin
			s_d.valve = s_q.safe_pos;
		end
		// Read data captured in the setup cycle
		if (setup_rd) begin
			s_d.rdata = 32'h0000_0000;
			unique case (PADDR)
				valve_head_pkg::REG_NODE: begin
					s_d.rdata[5:0] = s_q.node_addr;
					s_d.rdata[valve_head_pkg::NODE_BAUD_LSB +: 2] = s_q.baud;
					s_d.rdata[valve_head_pkg::NODE_FORBID] =
						s_q.baud == valve_head_pkg::BAUD_BAD;
					s_d.rdata[valve_head_pkg::NODE_VALID] =
						s_q.state == valve_head_pkg::CFG_RUN;
				end
				valve_head_pkg::REG_CTRL: begin
					s_d.rdata[valve_head_pkg::CTRL_LINK_UP] = s_q.link_up;
				end
				valve_head_pkg::REG_ACTIVE: begin
					s_d.rdata[7:0] =
						(s_q.in_asm == valve_head_pkg::ASM_IN_POS) ?
						valve_head_pkg::INST_IN_POS :
						valve_head_pkg::INST_IN_FB;
					s_d.rdata[15:8] = valve_head_pkg::INST_OUT;
				end
				valve_head_pkg::REG_OUT: begin
					s_d.rdata[2:0] = s_q.out_cmd;
				end
				valve_head_pkg::REG_IN: begin
					s_d.rdata = {14'h0000, in_len, in_b1, in_b0};
				end
				valve_head_pkg::REG_EXPL_PATH: begin
					s_d.rdata[23:0] = s_q.expl_path;
				end
				valve_head_pkg::REG_EXPL_DATA: begin
					s_d.rdata = expl_data;
				end
				valve_head_pkg::REG_SAFETY: begin
					s_d.rdata[2:0] = s_q.safe_pos;
					s_d.rdata[valve_head_pkg::SAFE_RETAIN] = s_q.safe_retain;
				end
				valve_head_pkg::REG_STATUS: begin
					s_d.rdata[2:0] = s_q.valve;
					s_d.rdata[7:4] = fb_s;
					s_d.rdata[8] = !s_q.link_up;
				end
				default: begin
					s_d.rdata = 32'h0000_0000; // Path and unmapped
				end
			endcase
		end
	end
	////////////////////////////////////////////////////////////////
	// State register: restart from power-up defaults
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			s_q.state <= valve_head_pkg::CFG_SETTLE;
			s_q.settle <= 2'h0;
			s_q.node_addr <= 6'h00;
			s_q.baud <= valve_head_pkg::BAUD_125K;
			s_q.in_asm <= valve_head_pkg::ASM_IN_FB;
			s_q.out_cmd <= 3'h0;
			s_q.safe_pos <= valve_head_pkg::SAFE_POS_RESET;
			s_q.safe_retain <= 1'b0;
			s_q.link_up <= 1'b0;
			s_q.valve <= 3'h0;
			s_q.expl_path <= 24'h00_0000;
			s_q.rdata <= 32'h0000_0000;
		end else begin
			s_q <= s_d;
		end
	end
	assign NODE_ADDR = s_q.node_addr;
	assign BAUD_SEL = s_q.baud;
	assign BAUD_FORBIDDEN = s_q.baud == valve_head_pkg::BAUD_BAD;
	assign CFG_VALID = s_q.state == valve_head_pkg::CFG_RUN;
	assign VALVE_DRIVE = s_q.valve;
	////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RESET_N);
	a_addr_capture: assert property (
		s_q.state == valve_head_pkg::CFG_SETTLE &&
		s_q.settle == valve_head_pkg::SETTLE_LAST |=>
		NODE_ADDR == $past(dip_s[5:0]) && CFG_VALID)
		else $error("node address not taken from switches");
	a_baud_capture: assert property (
		s_q.state == valve_head_pkg::CFG_SETTLE &&
		s_q.settle == valve_head_pkg::SETTLE_LAST |=>
		BAUD_SEL == {$past(dip_s[7]), $past(dip_s[6])})
		else $error("bit rate not taken from switches");
	a_cfg_frozen: assert property (
		CFG_VALID && $past(CFG_VALID) |->
		$stable(NODE_ADDR) && $stable(BAUD_SEL))
		else $error("configuration changed during operation");
	a_restart_seq: assert property (
		wr_en && PADDR == valve_head_pkg::REG_CTRL &&
		PWDATA[valve_head_pkg::CTRL_RESTART] |=>
		!CFG_VALID [*3] ##1 CFG_VALID)
		else $error("restart did not recapture switches");
	a_valve_follow: assert property (
		s_q.link_up |=> VALVE_DRIVE == $past(s_q.out_cmd))
		else $error("valves do not follow output assembly");
	a_safe_state: assert property (
		!s_q.link_up && !s_q.safe_retain |=>
		VALVE_DRIVE == $past(s_q.safe_pos))
		else $error("valves not in safety state on bus loss");
	a_in_unused: assert property (
		PSEL && PENABLE && !PWRITE && PADDR == valve_head_pkg::REG_IN
		|-> PRDATA[7:4] == 4'h0 && PRDATA[31:18] == 14'h0000)
		else $error("unused input bits not zero");
	a_pos_byte: assert property (
		setup_rd && PADDR == valve_head_pkg::REG_IN &&
		s_q.in_asm == valve_head_pkg::ASM_IN_POS |=>
		PRDATA[15:8] == $past(POSITION_MM) && PRDATA[17:16] == 2'h2)
		else $error("position byte missing from second assembly");
	a_fb_only: assert property (
		setup_rd && PADDR == valve_head_pkg::REG_IN &&
		s_q.in_asm == valve_head_pkg::ASM_IN_FB |=>
		PRDATA[15:8] == 8'h00 && PRDATA[3:0] == $past(fb_s))
		else $error("first assembly carries wrong data");
	a_path_refused: assert property (
		PSEL && PENABLE && PWRITE && PADDR == valve_head_pkg::REG_PATH
		&& !path_in_ok |-> PSLVERR ##1 $stable(s_q.in_asm))
		else $error("bad connection path accepted");
	c_restart: cover property (s_q.state == valve_head_pkg::CFG_SETTLE
		##1 s_q.state == valve_head_pkg::CFG_RUN);
	c_bus_loss: cover property (s_q.link_up ##1 !s_q.link_up);
	c_expl_read: cover property (setup_rd &&
		PADDR == valve_head_pkg::REG_EXPL_DATA &&
		expl_kind != valve_head_pkg::ASM_NONE);
endmodule // valve_head_node

// File: valve_head_pkg.sv
// Constants, types and register map of the valve head node block.
// Assumes APB with 32-bit data and byte addresses.
package valve_head_pkg;
	////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] REG_NODE = 8'h00;
	localparam logic [7:0] REG_CTRL = 8'h04;
	localparam logic [7:0] REG_ACTIVE = 8'h08;
	localparam logic [7:0] REG_PATH = 8'h0C;
	localparam logic [7:0] REG_OUT = 8'h10;
	localparam logic [7:0] REG_IN = 8'h14;
	localparam logic [7:0] REG_EXPL_PATH = 8'h18;
	localparam logic [7:0] REG_EXPL_DATA = 8'h1C;
	localparam logic [7:0] REG_SAFETY = 8'h20;
	localparam logic [7:0] REG_STATUS = 8'h24;
	////////////////////////////////////////////////////////////////
	// Field positions
	localparam int CTRL_RESTART = 0;
	localparam int CTRL_LINK_UP = 1;
	localparam int PATH_CONSUMED = 24;
	localparam int SAFE_RETAIN = 8;
	localparam int NODE_BAUD_LSB = 8;
	localparam int NODE_FORBID = 12;
	localparam int NODE_VALID = 16;
	localparam int EXPL_OK = 31;
	////////////////////////////////////////////////////////////////
	// Assembly addressing: class, instances, data attribute
	localparam logic [7:0] ASM_CLASS = 8'h04;
	localparam logic [7:0] INST_IN_FB = 8'h01;
	localparam logic [7:0] INST_IN_POS = 8'h02;
	localparam logic [7:0] INST_OUT = 8'h15;
	localparam logic [7:0] ASM_ATTR = 8'h03;
	////////////////////////////////////////////////////////////////
	// Bit rate codes from switch 8 and switch 7
	localparam logic [1:0] BAUD_125K = 2'h0;
	localparam logic [1:0] BAUD_250K = 2'h1;
	localparam logic [1:0] BAUD_500K = 2'h2;
	localparam logic [1:0] BAUD_BAD = 2'h3;
	////////////////////////////////////////////////////////////////
	// Reset values and timing
	localparam logic [2:0] SAFE_POS_RESET = 3'h0;
	localparam logic [1:0] SETTLE_LAST = 2'h2;
	localparam int SYNC_STAGES = 2;
	////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [1:0] {
		ASM_NONE, ASM_IN_FB, ASM_IN_POS, ASM_OUT_VALVES
	} asm_t;
	typedef enum logic {CFG_SETTLE, CFG_RUN} cfg_state_t;
endpackage
